// *** inc/aag_regs.vh ***
`ifndef AAG_REGS_VH
`define AAG_REGS_VH

// Bus widths
`define AAG_ADDR_W        16
`define AAG_DATA_W        16

// Memory map: inclusive bounds of each area
`define AAG_ROM_LO        16'h0000
`define AAG_ROM_HI        16'h3FFF
`define AAG_RAM_LO        16'h4000
`define AAG_RAM_HI        16'h5FFF
`define AAG_CTRL_LO       16'h6000
`define AAG_CTRL_HI       16'h601F
`define AAG_FLASH_LO      16'h8000
`define AAG_FLASH_HI      16'hFFFF

// Area codes
`define AAG_AREA_ROM      2'h0
`define AAG_AREA_RAM      2'h1
`define AAG_AREA_FLASH    2'h2
`define AAG_AREA_CTRL     2'h3

// Operation codes, also the bit position in a permission entry
`define AAG_OP_READ       2'h0
`define AAG_OP_WRITE      2'h1
`define AAG_OP_DELETE     2'h2
`define AAG_OP_EXEC       2'h3

// Permission table layout: index = mode * stride + source * areas + target
`define AAG_PERM_W        4
`define AAG_N_ENTRIES     18
`define AAG_FUSE_W        72
`define AAG_N_AREAS       5'h03
`define AAG_MODE_STRIDE   5'h09
`define AAG_IDX_W         5
`define AAG_IDX_LAST      5'h11
`define AAG_IDX_LOCK      5'h1F
`define AAG_LOCK_BIT      0

// Default entries after reset
`define AAG_DEF_USER_PERM 4'h0
`define AAG_DEF_PRIV_PERM 4'hF

// Load count at which manufacturing settings are taken after reset release; the load state lasts one cycle more
`define AAG_LOAD_CYCLES   3

// One-hot states
`define AAG_ST_LOAD       4'h1
`define AAG_ST_IDLE       4'h2
`define AAG_ST_MEM        4'h4
`define AAG_ST_RSP        4'h8

`endif

// *** hdl/aag_area_decode.v ***
`timescale 1ns/1ps
`include "aag_regs.vh"

module aag_area_decode (
  // Address in
  input  wire [`AAG_ADDR_W-1:0] addr,
  // Decoded area
  output reg  [1:0]             area,
  output reg                    hit
);

  always @* begin
    area = `AAG_AREA_ROM;
    hit  = 1'b1;
    if (addr >= `AAG_ROM_LO && addr <= `AAG_ROM_HI) begin
      area = `AAG_AREA_ROM;
    end else if (addr >= `AAG_RAM_LO && addr <= `AAG_RAM_HI) begin
      area = `AAG_AREA_RAM;
    end else if (addr >= `AAG_CTRL_LO && addr <= `AAG_CTRL_HI) begin
      area = `AAG_AREA_CTRL;
    end else if (addr >= `AAG_FLASH_LO && addr <= `AAG_FLASH_HI) begin
      area = `AAG_AREA_FLASH;
    end else begin
      hit = 1'b0;
    end
  end

endmodule

// *** hdl/aag_area_access_guard_unit.v ***
// How it works
// - Every read, write, delete and execute request is checked, with privilege and user mode as separate subjects.
// - Only privileged code may write, delete or lock permission entries; user attempts change nothing.
// - ROM, RAM and flash are all decoded as guarded areas; anything unmapped is refused.
// - The decision uses the area the code runs from, the area addressed and the operation.
// - The decision is made before the memory sees the request; a refused one never reaches it and returns zero data.
// - No bypass exists: memory access is granted only by the selected permission bit.
// - Reset puts every permission entry at a fixed default value.
// - Privileged code may replace default entries with its own initial values.
// - Entries may come from manufacturing fuse settings loaded after reset or from run-time writes.
// - Entries are managed through control registers in a dedicated address window.
`timescale 1ns/1ps
`include "aag_regs.vh"

module aag_area_access_guard_unit #(
  parameter ADDR_W      = `AAG_ADDR_W,
  parameter DATA_W      = `AAG_DATA_W,
  parameter LOAD_CYCLES = `AAG_LOAD_CYCLES
) (
  // Clock and reset
  input  wire                 REF_CLK,
  input  wire                 SYS_RST,
  // Manufacturing settings
  input  wire                 FUSE_LOAD,
  input  wire [`AAG_FUSE_W-1:0] FUSE_PERM,
  // Core request
  input  wire                 REQ_VALID,
  output wire                 REQ_READY,
  input  wire                 REQ_PRIV,
  input  wire [1:0]           REQ_OP,
  input  wire [ADDR_W-1:0]    REQ_FETCH_ADDR,
  input  wire [ADDR_W-1:0]    REQ_ADDR,
  input  wire [DATA_W-1:0]    REQ_WDATA,
  // Core response
  output wire                 RSP_VALID,
  output wire                 RSP_VIOLATION,
  output wire [DATA_W-1:0]    RSP_RDATA,
  // Memory side
  output wire                 MEM_VALID,
  output wire [1:0]           MEM_OP,
  output wire [ADDR_W-1:0]    MEM_ADDR,
  output wire [DATA_W-1:0]    MEM_WDATA,
  input  wire                 MEM_DONE,
  input  wire [DATA_W-1:0]    MEM_RDATA
);

  function [`AAG_IDX_W-1:0] perm_index;
    input       mode;
    input [1:0] src;
    input [1:0] tgt;
    begin
      perm_index = (mode ? `AAG_MODE_STRIDE : {`AAG_IDX_W{1'b0}})
                   + ({3'b000, src} * `AAG_N_AREAS) + {3'b000, tgt};
    end
  endfunction

  reg  [3:0]               state_reg;
  reg  [3:0]               state_next;
  reg  [7:0]               load_cnt_reg;
  reg                      fuse_load_s1_reg;
  reg                      fuse_load_s2_reg;
  reg  [`AAG_FUSE_W-1:0]   fuse_perm_s1_reg;
  reg  [`AAG_FUSE_W-1:0]   fuse_perm_s2_reg;
  reg  [`AAG_PERM_W-1:0]   perm_reg [0:`AAG_N_ENTRIES-1];
  reg                      lock_reg;
  reg                      mem_valid_reg;
  reg  [1:0]               mem_op_reg;
  reg  [ADDR_W-1:0]        mem_addr_reg;
  reg  [DATA_W-1:0]        mem_wdata_reg;
  reg                      rsp_valid_reg;
  reg                      rsp_viol_reg;
  reg  [DATA_W-1:0]        rsp_rdata_reg;
  wire [1:0]               src_area;
  wire                     src_hit;
  wire [1:0]               tgt_area;
  wire                     tgt_hit;
  wire [`AAG_IDX_W-1:0]    sel_idx;
  wire [`AAG_PERM_W-1:0]   sel_perm;
  wire                     src_ok;
  wire                     tgt_mem;
  wire                     tgt_ctrl;
  wire                     mem_permit;
  wire [`AAG_IDX_W-1:0]    cfg_idx;
  wire                     cfg_entry;
  wire                     cfg_lock;
  wire                     cfg_permit;
  wire                     cfg_change;
  wire                     req_take;
  wire [DATA_W-1:0]        cfg_rdata;
  integer                  i;

  aag_area_decode u_src_decode (
    .addr (REQ_FETCH_ADDR),
    .area (src_area),
    .hit  (src_hit)
  );

  aag_area_decode u_tgt_decode (
    .addr (REQ_ADDR),
    .area (tgt_area),
    .hit  (tgt_hit)
  );

  assign req_take   = (state_reg == `AAG_ST_IDLE) && REQ_VALID;
  assign REQ_READY  = (state_reg == `AAG_ST_IDLE);

  // Code may only run from a memory area, never from the control window
  assign src_ok     = src_hit && (src_area != `AAG_AREA_CTRL);
  assign tgt_mem    = tgt_hit && (tgt_area != `AAG_AREA_CTRL);
  assign tgt_ctrl   = tgt_hit && (tgt_area == `AAG_AREA_CTRL);
  assign sel_idx    = perm_index(REQ_PRIV, src_area, tgt_area);
  assign sel_perm   = perm_reg[sel_idx];
  assign mem_permit = src_ok && tgt_mem && sel_perm[REQ_OP];

  // Control window: entry index in the low address bits
  assign cfg_idx    = REQ_ADDR[`AAG_IDX_W-1:0];
  assign cfg_entry  = (cfg_idx <= `AAG_IDX_LAST);
  assign cfg_lock   = (cfg_idx == `AAG_IDX_LOCK);
  assign cfg_permit = tgt_ctrl && src_ok && REQ_PRIV && (cfg_entry || cfg_lock)
                      && (REQ_OP != `AAG_OP_EXEC)
                      && ((REQ_OP == `AAG_OP_READ) || !lock_reg);
  assign cfg_change = req_take && cfg_permit && (REQ_OP != `AAG_OP_READ);
  assign cfg_rdata  = cfg_lock ? {{(DATA_W-1){1'b0}}, lock_reg}
                               : {{(DATA_W-`AAG_PERM_W){1'b0}}, perm_reg[cfg_idx]};

  always @* begin
    state_next = state_reg;
    case (state_reg)
      `AAG_ST_LOAD: begin
        if (load_cnt_reg == LOAD_CYCLES[7:0]) begin
          state_next = `AAG_ST_IDLE;
        end
      end
      `AAG_ST_IDLE: begin
        if (req_take && mem_permit) begin
          state_next = `AAG_ST_MEM;
        end else if (req_take) begin
          state_next = `AAG_ST_RSP;
        end
      end
      `AAG_ST_MEM: begin
        if (MEM_DONE) begin
          state_next = `AAG_ST_RSP;
        end
      end
      `AAG_ST_RSP: begin
        state_next = `AAG_ST_IDLE;
      end
      default: begin
        state_next = `AAG_ST_LOAD;
      end
    endcase
  end

  // Fuse settings come from outside this clock domain
  always @(posedge REF_CLK) begin
    fuse_load_s1_reg <= FUSE_LOAD;
    fuse_load_s2_reg <= fuse_load_s1_reg;
    fuse_perm_s1_reg <= FUSE_PERM;
    fuse_perm_s2_reg <= fuse_perm_s1_reg;
  end

  always @(posedge REF_CLK) begin
    if (SYS_RST) begin
      state_reg    <= `AAG_ST_LOAD;
      load_cnt_reg <= 8'h00;
      lock_reg     <= 1'b0;
      for (i = 0; i < `AAG_N_ENTRIES; i = i + 1) begin
        perm_reg[i] <= (i >= `AAG_MODE_STRIDE) ? `AAG_DEF_PRIV_PERM : `AAG_DEF_USER_PERM;
      end
    end else begin
      state_reg <= state_next;
      if (state_reg == `AAG_ST_LOAD) begin
        load_cnt_reg <= load_cnt_reg + 8'h01;
        if (load_cnt_reg == LOAD_CYCLES[7:0] && fuse_load_s2_reg) begin
          for (i = 0; i < `AAG_N_ENTRIES; i = i + 1) begin
            perm_reg[i] <= fuse_perm_s2_reg[i*`AAG_PERM_W +: `AAG_PERM_W];
          end
        end
      end
      if (cfg_change && cfg_lock && REQ_OP == `AAG_OP_WRITE) begin
        lock_reg <= REQ_WDATA[`AAG_LOCK_BIT];
      end
      if (cfg_change && cfg_entry) begin
        if (REQ_OP == `AAG_OP_WRITE) begin
          perm_reg[cfg_idx] <= REQ_WDATA[`AAG_PERM_W-1:0];
        end else begin
          perm_reg[cfg_idx] <= (cfg_idx >= `AAG_MODE_STRIDE) ? `AAG_DEF_PRIV_PERM
                                                            : `AAG_DEF_USER_PERM;
        end
      end
    end
  end

  // Memory request only after a grant
  always @(posedge REF_CLK) begin
    if (SYS_RST) begin
      mem_valid_reg <= 1'b0;
      mem_op_reg    <= `AAG_OP_READ;
      mem_addr_reg  <= {ADDR_W{1'b0}};
      mem_wdata_reg <= {DATA_W{1'b0}};
    end else begin
      if (req_take && mem_permit) begin
        mem_valid_reg <= 1'b1;
        mem_op_reg    <= REQ_OP;
        mem_addr_reg  <= REQ_ADDR;
        mem_wdata_reg <= REQ_WDATA;
      end else if (state_reg == `AAG_ST_MEM && MEM_DONE) begin
        mem_valid_reg <= 1'b0;
      end
    end
  end

  always @(posedge REF_CLK) begin
    if (SYS_RST) begin
      rsp_valid_reg <= 1'b0;
      rsp_viol_reg  <= 1'b0;
      rsp_rdata_reg <= {DATA_W{1'b0}};
    end else begin
      rsp_valid_reg <= 1'b0;
      rsp_viol_reg  <= 1'b0;
      rsp_rdata_reg <= {DATA_W{1'b0}};
      if (req_take && !mem_permit) begin
        rsp_valid_reg <= 1'b1;
        rsp_viol_reg  <= !cfg_permit;
        if (cfg_permit && REQ_OP == `AAG_OP_READ) begin
          rsp_rdata_reg <= cfg_rdata;
        end
      end else if (state_reg == `AAG_ST_MEM && MEM_DONE) begin
        rsp_valid_reg <= 1'b1;
        if (mem_op_reg == `AAG_OP_READ || mem_op_reg == `AAG_OP_EXEC) begin
          rsp_rdata_reg <= MEM_RDATA;
        end
      end
    end
  end

  assign MEM_VALID     = mem_valid_reg;
  assign MEM_OP        = mem_op_reg;
  assign MEM_ADDR      = mem_addr_reg;
  assign MEM_WDATA     = mem_wdata_reg;
  assign RSP_VALID     = rsp_valid_reg;
  assign RSP_VIOLATION = rsp_viol_reg;
  assign RSP_RDATA     = rsp_rdata_reg;

endmodule

// *** test/aag_properties.sv ***
`timescale 1ns/1ps
module aag_properties #(
  parameter ADDR_W = 16,
  parameter DATA_W = 16
) (
  // Clock and reset
  input wire              REF_CLK,
  input wire              SYS_RST,
  // Core side
  input wire              REQ_VALID,
  input wire              REQ_READY,
  input wire              REQ_PRIV,
  input wire [1:0]        REQ_OP,
  input wire [ADDR_W-1:0] REQ_FETCH_ADDR,
  input wire [ADDR_W-1:0] REQ_ADDR,
  input wire              RSP_VALID,
  input wire              RSP_VIOLATION,
  input wire [DATA_W-1:0] RSP_RDATA,
  // Memory side
  input wire              MEM_VALID,
  input wire [1:0]        MEM_OP,
  input wire [ADDR_W-1:0] MEM_ADDR,
  input wire              MEM_DONE
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  wire take = REQ_VALID && REQ_READY;
  wire tc   = REQ_ADDR >= 16'h6000 && REQ_ADDR <= 16'h601F;
  wire tu   = REQ_ADDR > 16'h601F && REQ_ADDR < 16'h8000;
  wire sb   = REQ_FETCH_ADDR >= 16'h6000 && REQ_FETCH_ADDR < 16'h8000;
  a_refuse_zero: assert property (RSP_VALID && RSP_VIOLATION |-> RSP_RDATA == 0)
    else $error("refused answer carries data");
  a_take_answer: assert property (take |=> MEM_VALID != RSP_VALID)
    else $error("taken request neither forwarded nor answered");
  a_mem_forward: assert property (take ##1 MEM_VALID |-> MEM_ADDR == $past(REQ_ADDR) && MEM_OP == $past(REQ_OP))
    else $error("memory request differs from core request");
  a_ctrl_local: assert property (take && (tc || tu || sb) |=> !MEM_VALID && RSP_VALID)
    else $error("control or bad access reached memory");
  a_bad_refused: assert property (take && (tu || sb) |=> RSP_VIOLATION)
    else $error("unmapped target or bad source not refused");
  a_exec_ctrl: assert property (take && tc && REQ_OP == 2'h3 |=> RSP_VIOLATION)
    else $error("execute on control window not refused");
  a_done_answer: assert property (MEM_VALID && MEM_DONE |=> RSP_VALID && !RSP_VIOLATION && !MEM_VALID)
    else $error("memory completion not answered");
  a_mem_hold: assert property (MEM_VALID && !MEM_DONE |=> MEM_VALID && $stable(MEM_ADDR) && $stable(MEM_OP))
    else $error("memory request dropped or changed");
  a_rsp_gap: assert property (RSP_VALID |-> !REQ_READY ##1 !RSP_VALID)
    else $error("answer not a single cycle");
  a_user_cfg_refused: assert property (take && tc && !REQ_PRIV |=> RSP_VALID && RSP_VIOLATION)
    else $error("user mode control access not refused");
endmodule
bind aag_area_access_guard_unit aag_properties #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) aag_properties_inst (
  .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY), .REQ_PRIV(REQ_PRIV),
  .REQ_OP(REQ_OP),
  .REQ_FETCH_ADDR(REQ_FETCH_ADDR), .REQ_ADDR(REQ_ADDR), .RSP_VALID(RSP_VALID), .RSP_VIOLATION(RSP_VIOLATION),
  .RSP_RDATA(RSP_RDATA), .MEM_VALID(MEM_VALID), .MEM_OP(MEM_OP), .MEM_ADDR(MEM_ADDR), .MEM_DONE(MEM_DONE));

// *** test/aag_mem_model.sv ***
`timescale 1ns/1ps
module aag_mem_model (
  // Clock and reset
  input  wire         REF_CLK,
  input  wire         SYS_RST,
  // Request from guard
  input  wire         MEM_VALID,
  input  wire  [15:0] MEM_ADDR,
  // Answer
  output wire         MEM_DONE,
  output logic [15:0] MEM_RDATA
);
  logic [1:0]  wait_reg;
  logic [15:0] last_reg;
  // Delay follows the low address bits, so some requests finish in their first cycle
  assign MEM_DONE = MEM_VALID && wait_reg == MEM_ADDR[1:0];
  // Outside completion the data lines show the inverse of the last word
  always_comb MEM_RDATA = MEM_DONE ? MEM_ADDR ^ 16'hA5A5 : ~last_reg;
  always @(posedge REF_CLK) begin
    wait_reg <= (SYS_RST || MEM_DONE || !MEM_VALID) ? 2'h0 : wait_reg + 2'h1;
    last_reg <= SYS_RST ? 16'h0000 : MEM_DONE ? MEM_RDATA : last_reg;
  end
endmodule

// *** test/test_area_access_guard_unit.sv ***
`timescale 1ns/1ps
module test_area_access_guard_unit;
  logic        REF_CLK = 0, SYS_RST = 1, FUSE_LOAD = 0, REQ_VALID = 0, REQ_PRIV = 0, lock, mem_seen;
  logic [71:0] FUSE_PERM = 0;
  logic [1:0]  REQ_OP = 0;
  logic [15:0] REQ_FETCH_ADDR = 0, REQ_ADDR = 0, REQ_WDATA = 0;
  wire         REQ_READY, RSP_VALID, RSP_VIOLATION, MEM_VALID, MEM_DONE;
  wire  [1:0]  MEM_OP;
  wire  [15:0] RSP_RDATA, MEM_ADDR, MEM_WDATA, MEM_RDATA;
  logic [3:0]  tbl [18];
  logic [17:0] mem_fwd;
  logic [31:0] seed = 32'h129b, r, q;
  int          n_errors = 0, checked = 0, cyc = 0;

  aag_area_access_guard_unit aag_area_access_guard_unit_inst (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST),
    .FUSE_LOAD(FUSE_LOAD), .FUSE_PERM(FUSE_PERM), .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY),
    .REQ_PRIV(REQ_PRIV), .REQ_OP(REQ_OP), .REQ_FETCH_ADDR(REQ_FETCH_ADDR), .REQ_ADDR(REQ_ADDR),
    .REQ_WDATA(REQ_WDATA), .RSP_VALID(RSP_VALID), .RSP_VIOLATION(RSP_VIOLATION), .RSP_RDATA(RSP_RDATA),
    .MEM_VALID(MEM_VALID), .MEM_OP(MEM_OP), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA),
    .MEM_DONE(MEM_DONE), .MEM_RDATA(MEM_RDATA));
  aag_mem_model aag_mem_model_inst (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .MEM_VALID(MEM_VALID),
    .MEM_ADDR(MEM_ADDR), .MEM_DONE(MEM_DONE), .MEM_RDATA(MEM_RDATA));

  initial forever #50 REF_CLK = ~REF_CLK;
  // Remember what reached the memory side during the current request
  always @(negedge REF_CLK) begin
    if (MEM_VALID) begin
      mem_seen = 1'b1;
      mem_fwd = {MEM_OP, MEM_WDATA};
    end
  end
  always @(posedge REF_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors++;
      results;
    end
  end

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function int ar(logic [15:0] a);
    return a < 16'h4000 ? 0 : a < 16'h6000 ? 1 : a < 16'h6020 ? 3 : a < 16'h8000 ? 4 : 2;
  endfunction

  task results;
    if (n_errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task cmp(logic [31:0] got, logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task rst(logic fl);
    @(negedge REF_CLK);
    FUSE_LOAD = fl;
    FUSE_PERM = {rnd(), rnd(), 8'(rnd())};
    SYS_RST = 1;
    repeat (8) @(negedge REF_CLK);
    SYS_RST = 0;
    for (int i = 0; i < 18; i++) tbl[i] = fl ? FUSE_PERM[4*i+:4] : (i < 9 ? 4'h0 : 4'hF);
    lock = 0;
  endtask
  // One request; the expected answer and table update are worked out alongside
  task acc(logic p, logic [1:0] op, logic [15:0] fa, logic [15:0] a, logic [15:0] wd);
    int s, t;
    logic ok;
    logic [15:0] rd;
    logic [4:0] ci;
    s = ar(fa);
    t = ar(a);
    ci = a[4:0];
    ok = 0;
    rd = 0;
    if (s < 3 && t == 3) begin
      ok = p && op != 3 && (ci < 18 || ci == 31) && (op == 0 || !lock);
      if (ok && ci == 31) begin
        if (op == 1) lock = wd[0];
        else if (op == 0) rd = {15'h0000, lock};
      end else if (ok && op == 1) tbl[ci] = wd[3:0];
      else if (ok && op == 2) tbl[ci] = ci < 9 ? 4'h0 : 4'hF;
      else if (ok) rd = {12'h000, tbl[ci]};
    end else if (s < 3 && t < 3) begin
      ok = tbl[p*9+s*3+t][op];
      if (ok && (op == 0 || op == 3)) rd = a ^ 16'hA5A5;
    end
    @(negedge REF_CLK);
    {REQ_PRIV, REQ_OP, REQ_FETCH_ADDR, REQ_ADDR, REQ_WDATA} = {p, op, fa, a, wd};
    REQ_VALID = 1;
    mem_seen = 0;
    while (REQ_READY !== 1'b1) @(negedge REF_CLK);
    @(negedge REF_CLK);
    REQ_VALID = 0;
    while (RSP_VALID !== 1'b1) @(negedge REF_CLK);
    cmp({RSP_VIOLATION, RSP_RDATA}, {!ok, rd});
    cmp(mem_seen, ok && s < 3 && t < 3);
    if (ok && s < 3 && t < 3) cmp(mem_fwd, {op, wd});
  endtask

  initial begin
    rst(0);
    for (int i = 0; i < 18; i++) acc(1, 0, 16'h0100, {11'h300, 5'(i)}, 0);
    acc(0, 0, 16'h0100, 16'h4000, 0);
    acc(1, 0, 16'h0100, 16'h4001, 0);
    acc(0, 1, 16'h0100, 16'h6001, 16'h0009);
    acc(1, 1, 16'h0100, 16'h6001, 16'h0009);
    acc(0, 0, 16'h0100, 16'h4002, 0);
    acc(0, 1, 16'h0100, 16'h4002, 0);
    acc(0, 0, 16'h4100, 16'h4002, 0);
    acc(1, 3, 16'h0100, 16'h6001, 0);
    acc(1, 0, 16'h6004, 16'h0000, 0);
    acc(1, 0, 16'h0100, 16'h7000, 0);
    acc(1, 2, 16'h0100, 16'h6001, 0);
    acc(0, 0, 16'h0100, 16'h4002, 0);
    repeat (150) begin
      r = rnd();
      q = rnd();
      acc(1, 1, 16'h0100, {11'h300, 5'(q % 18)}, q[31:16]);
      acc(r[0], r[2:1], q[15:0] & 16'hDFFF, r[31:16] & 16'hDFFF, r[15:0]);
    end
    acc(0, 1, 16'h0100, 16'h601F, 16'h0001);
    acc(1, 1, 16'h0100, 16'h601F, 16'h0001);
    acc(1, 0, 16'h0100, 16'h601F, 0);
    acc(1, 1, 16'h0100, 16'h601F, 16'h0000);
    acc(1, 1, 16'h0100, 16'h6002, 16'h000F);
    acc(1, 0, 16'h0100, 16'h6002, 0);
    rst(1);
    for (int i = 0; i < 18; i++) acc(1, 0, 16'h4100, {11'h300, 5'(i)}, 0);
    repeat (40) begin
      r = rnd();
      acc(r[0], r[2:1], r[18:3] & 16'hDFFF, r[31:16] & 16'hDFFF, 0);
    end
    results;
  end
endmodule
